// [adcsq_pkg.sv]
// constants and types shared by the serial readout sequencer
package adcsq_pkg;

  // system clock
  localparam int unsigned CLK_HZ = 100_000_000;

  // internal oscillator rates for the two notch settings, in Hz
  localparam int unsigned OSC_60HZ_NOTCH_HZ = 153_600;
  localparam int unsigned OSC_50HZ_NOTCH_HZ = 128_000;
  // mclk cycles per oscillator tick (longest period, rounded down)
  localparam logic [9:0] OSC_DIV_60 = 10'(CLK_HZ / OSC_60HZ_NOTCH_HZ);
  localparam logic [9:0] OSC_DIV_50 = 10'(CLK_HZ / OSC_50HZ_NOTCH_HZ);

  // oscillator ticks per filter first-null period
  localparam logic [11:0] NULL_DIV = 12'd2560;

  // internal serial clock is the oscillator divided by 8: 4 ticks per half period
  localparam logic [1:0] SCK_HALF_LAST = 2'h3;

  // output word layout
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned RESULT_BITS = 20;
  localparam int unsigned EXTRA_BITS = 8;
  localparam int unsigned BIT_EOC = 23;
  localparam int unsigned BIT_CH = 22;
  localparam logic [4:0] LAST_BIT_IDX = 5'd23;

  // power-on reset hold, 0.5 ms
  localparam int unsigned POR_TIME_US = 500;
  localparam int unsigned POR_CYCLES = POR_TIME_US * (CLK_HZ / 1_000_000);

  // time without edges on the frequency pin before it counts as static, 1 ms
  localparam int unsigned FO_TIMEOUT_US = 1000;
  localparam int unsigned FO_TIMEOUT_CYCLES = FO_TIMEOUT_US * (CLK_HZ / 1_000_000);

  // result fifo shape: 20 code bits, sign, range flag
  localparam int unsigned FIFO_WIDTH = RESULT_BITS + 2;
  localparam int unsigned FIFO_DEPTH = 4;

  // sequencer states
  typedef enum logic [1:0] {
    ST_POR,
    ST_CONV,
    ST_SLEEP,
    ST_OUTPUT
  } adcsq_state_t;

endpackage

// [adcsq_sequencer.sv]
// result fifo and serial readout sequencer of the converter
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo with valid/ready on both sides
module adcsq_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0] wr_ptr_reg;  // next write slot
  logic [AW-1:0] rd_ptr_reg;  // next read slot
  logic [AW:0] count_reg;  // words held
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // adcsq_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE_01: chip select low enables output, wakes device
// RULE_02: sleep after conversion while chip select high
// RULE_03: chip select rise mid-transfer aborts, restarts conversion
// RULE_04: output released while chip select high
// RULE_05: conversion/sleep with select low shows status
// RULE_06: internal mode drives serial clock pin
// RULE_07: external mode: host drives serial clock
// RULE_08: clock mode sampled at reset, select fall
// RULE_09: high pin selects internal, low external
// RULE_10: static frequency pin picks 50/60 notch
// RULE_11: toggling frequency pin clocks conversion, null/2560
// RULE_12: two-channel variant alternates inputs each cycle
// RULE_13: reference endpoints map to all-ones/all-zeros codes
// RULE_14: states run conversion, sleep, output, repeat
// RULE_15: sleep keeps result unchanged in shifter
// RULE_16: output starts on rising clock, select low
// RULE_17: data changes on falling clock edges
// RULE_18: output ends after 24 bits or select high
// RULE_19: word is the conversion just finished; code loads the oldest fifo result
// RULE_20: word ends on falling edge of 24th clock
// RULE_21: extra clocks after word read high
// RULE_22: four status bits then 20-bit result MSB-first
// RULE_23: end-of-conversion bit high while converting
// RULE_24: clocks ignored while chip select high
// RULE_25: power-on hold 0.5 ms, then conversion starts
module adcsq_sequencer
  import adcsq_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES = POR_CYCLES,
  parameter int unsigned FO_IDLE_CYCLES = FO_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sck_pin_i,
  output logic sck_pin_o,
  output logic sck_pin_oe,
  output logic sck_pullup_en,
  output logic sdo_pin_o,
  output logic sdo_pin_oe,
  // frequency select pin and variant strap
  input wire logic frequency_select_pin,
  input wire logic two_channel_variant,
  // converter front end
  output logic conv_start,
  output logic conv_channel,
  output logic conv_clk_en,
  output logic null_tick,
  output logic notch_50hz,
  output logic ext_osc_mode,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [RESULT_BITS-1:0] result_code,
  input wire logic result_sign_flag,
  input wire logic range_exceeded_flag,
  // status
  output logic awake,
  output logic conv_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic rst_meta_reg;  // reset release stage one
  logic rst_n_reg;  // synchronised reset
  logic [1:0] cs_sync_reg;  // chip select synchroniser
  logic [1:0] sck_sync_reg;  // serial clock synchroniser
  logic [1:0] fo_sync_reg;  // frequency pin synchroniser
  logic cs_d_reg;  // delayed chip select for edges
  logic sck_d_reg;  // delayed serial clock for edges
  logic fo_d_reg;  // delayed frequency pin for edges
  logic [1:0] sync_fill_reg;  // edges since reset release, saturating
  logic cs_s;
  logic sck_s;
  logic fo_s;

  // reset is released through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // two-flop synchronisers, then one delay stage for edge detection
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cs_sync_reg <= 2'h3;
      sck_sync_reg <= 2'h3;
      fo_sync_reg <= 2'h0;
      cs_d_reg <= 1'b1;
      sck_d_reg <= 1'b1;
      fo_d_reg <= 1'b0;
      sync_fill_reg <= '0;
    end else begin
      // frequency pin edges and the clock mode sample only count once the stages hold real pin values
      if (sync_fill_reg != 2'h3) begin
        sync_fill_reg <= sync_fill_reg + 1'b1;
      end
      cs_sync_reg <= {cs_sync_reg[0], cs_n_pin};
      sck_sync_reg <= {sck_sync_reg[0], sck_pin_i};
      fo_sync_reg <= {fo_sync_reg[0], frequency_select_pin};
      cs_d_reg <= cs_s;
      sck_d_reg <= sck_s;
      fo_d_reg <= fo_s;
    end
  end

  assign cs_s = cs_sync_reg[1];
  assign sck_s = sck_sync_reg[1];
  assign fo_s = fo_sync_reg[1];

  logic cs_fall;
  logic cs_rise;
  assign cs_fall = cs_d_reg && !cs_s;
  assign cs_rise = !cs_d_reg && cs_s;

  //////////////////////////////////////////////////////////////////////////////
  // conversion clock source
  logic [16:0] fo_idle_reg;  // cycles since last frequency pin edge
  logic ext_osc_reg;  // frequency pin is toggling
  logic [9:0] osc_div_reg;  // internal oscillator divider
  logic [11:0] null_cnt_reg;  // ticks within one null period
  logic osc_tick;
  logic fo_edge;

  // no false edge from the reset values of the stages
  assign fo_edge = (sync_fill_reg == 2'h3) && (fo_s ^ fo_d_reg);

  // an edge within the idle window means an external clock is present
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fo_idle_reg <= '0;
      ext_osc_reg <= 1'b0;
    end else if (fo_edge) begin
      fo_idle_reg <= '0;
      ext_osc_reg <= 1'b1;  // [RULE_11]
    end else if (fo_idle_reg == 17'(FO_IDLE_CYCLES - 1)) begin
      ext_osc_reg <= 1'b0;  // [RULE_10]
    end else begin
      fo_idle_reg <= fo_idle_reg + 1'b1;
    end
  end

  // internal oscillator: divider depends on the static pin level
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      osc_div_reg <= '0;
    end else if (osc_div_reg >= (fo_s ? OSC_DIV_50 : OSC_DIV_60) - 1'b1) begin
      osc_div_reg <= '0;  // [RULE_10]
    end else begin
      osc_div_reg <= osc_div_reg + 1'b1;
    end
  end

  // external mode ticks on rising pin edges, otherwise on the divider wrap
  assign osc_tick = ext_osc_reg ? (fo_s && !fo_d_reg) : (osc_div_reg == '0);  // [RULE_11]

  // null period marker for the filter: one per 2560 oscillator ticks
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      null_cnt_reg <= '0;
    end else if (osc_tick) begin
      null_cnt_reg <= (null_cnt_reg == NULL_DIV - 1'b1) ? '0 : null_cnt_reg + 1'b1;  // [RULE_11]
    end
  end

  assign conv_clk_en = osc_tick;
  assign null_tick = osc_tick && (null_cnt_reg == NULL_DIV - 1'b1);
  assign notch_50hz = !ext_osc_reg && fo_s;  // [RULE_10]
  assign ext_osc_mode = ext_osc_reg;

  //////////////////////////////////////////////////////////////////////////////
  // result fifo between filter and shifter
  logic fifo_valid;
  logic fifo_ready;
  logic [FIFO_WIDTH-1:0] fifo_data;
  adcsq_state_t state_reg;

  adcsq_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_n_reg),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data({range_exceeded_flag, result_sign_flag, result_code}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // drained only when a conversion is waiting for its result
  assign fifo_ready = (state_reg == ST_CONV);

  //////////////////////////////////////////////////////////////////////////////
  // serial clock mode and internal clock generator
  logic int_sck_reg;  // internal serial clock mode
  logic sck_gen_reg;  // generated clock level
  logic [1:0] sck_half_reg;  // ticks within a half period
  logic gen_run;
  logic gen_flip;
  logic sck_rise;
  logic sck_fall;

  // clock mode caught once after reset release and at each select fall
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      int_sck_reg <= 1'b1;
    end else begin
      // power-up sample waits until the synchroniser holds the pin level
      if ((sync_fill_reg == 2'h2) || cs_fall) begin
        int_sck_reg <= sck_s;  // [RULE_08] [RULE_09]
      end
    end
  end

  // nothing driven in the select-fall cycle, while the mode is still being sampled
  assign gen_run = int_sck_reg && !cs_s && !cs_fall &&
                   ((state_reg == ST_SLEEP) || (state_reg == ST_OUTPUT));
  assign gen_flip = gen_run && osc_tick && (sck_half_reg == SCK_HALF_LAST);

  // internal clock is the oscillator over 8, parked low when idle
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sck_gen_reg <= 1'b0;
      sck_half_reg <= '0;
    end else if (!gen_run) begin
      sck_gen_reg <= 1'b0;
      sck_half_reg <= '0;
    end else if (osc_tick) begin
      sck_half_reg <= sck_half_reg + 1'b1;
      if (gen_flip) begin
        sck_gen_reg <= !sck_gen_reg;  // [RULE_06]
      end
    end
  end

  // edges from the generator or the host, blind while select is high
  assign sck_rise = !cs_s && (int_sck_reg ? (gen_flip && !sck_gen_reg)
                                          : (sck_s && !sck_d_reg));  // [RULE_24] [RULE_07]
  assign sck_fall = !cs_s && (int_sck_reg ? (gen_flip && sck_gen_reg)
                                          : (!sck_s && sck_d_reg));  // [RULE_24] [RULE_07]

  assign sck_pin_o = sck_gen_reg;
  assign sck_pin_oe = int_sck_reg && !cs_s && !cs_fall;  // [RULE_06] [RULE_08]
  assign sck_pullup_en = int_sck_reg;  // [RULE_08]

  //////////////////////////////////////////////////////////////////////////////
  // conversion cycle sequencer and output shifter
  logic [16:0] por_cnt_reg;  // power-on hold counter
  logic [WORD_BITS-1:0] shift_reg;  // output word
  logic [4:0] bit_cnt_reg;  // falling edges within the word
  logic ch_reg;  // channel of the current conversion
  logic conv_start_reg;  // one-cycle start pulse

  // state, shifter and channel steer each other, so they share one process
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_POR;
      por_cnt_reg <= '0;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      ch_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= 1'b0;
      unique case (state_reg)
        // hold after power-up, then the first conversion on channel a
        ST_POR: begin
          if (por_cnt_reg == 17'(POR_HOLD_CYCLES - 1)) begin
            state_reg <= ST_CONV;  // [RULE_25]
            conv_start_reg <= 1'b1;
            ch_reg <= 1'b0;
          end else begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
          end
        end
        // wait for the oldest buffered result, then load the word
        ST_CONV: begin
          if (fifo_valid) begin
            // front end codes zero/full reference as 00000/fffff
            shift_reg <= {1'b0, ch_reg, fifo_data[RESULT_BITS], fifo_data[RESULT_BITS+1],
                          fifo_data[RESULT_BITS-1:0]};  // [RULE_22] [RULE_19] [RULE_13]
            state_reg <= ST_SLEEP;  // [RULE_02] [RULE_14]
          end
        end
        // word held untouched until select low and a rising clock
        ST_SLEEP: begin
          if (sck_rise) begin
            state_reg <= ST_OUTPUT;  // [RULE_16] [RULE_15]
            bit_cnt_reg <= '0;
          end
        end
        // shift on falling edges, ones fill behind the word
        ST_OUTPUT: begin
          if (cs_rise) begin
            state_reg <= ST_CONV;  // [RULE_03] [RULE_18]
            conv_start_reg <= 1'b1;
            ch_reg <= two_channel_variant && !ch_reg;  // [RULE_12]
          end else if (sck_fall) begin
            shift_reg <= {shift_reg[WORD_BITS-2:0], 1'b1};  // [RULE_17] [RULE_21]
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == LAST_BIT_IDX) begin
              state_reg <= ST_CONV;  // [RULE_20] [RULE_18] [RULE_14]
              conv_start_reg <= 1'b1;
              ch_reg <= two_channel_variant && !ch_reg;  // [RULE_12]
            end
          end
        end
      endcase
    end
  end

  assign conv_start = conv_start_reg;
  assign conv_channel = ch_reg;
  assign conv_busy = (state_reg == ST_CONV);

  //////////////////////////////////////////////////////////////////////////////
  // data pin drive
  logic sdo_reg;  // data pin level
  logic sdo_oe_reg;  // data pin enable

  // status bit high while converting; afterwards the word's top bit
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sdo_reg <= 1'b1;
      sdo_oe_reg <= 1'b0;
    end else begin
      if ((state_reg == ST_CONV) || (state_reg == ST_POR)) begin
        sdo_reg <= 1'b1;  // [RULE_23] [RULE_05] [RULE_21]
      end else begin
        sdo_reg <= shift_reg[BIT_EOC];  // [RULE_05] [RULE_17]
      end
      sdo_oe_reg <= !cs_s;  // [RULE_01] [RULE_04]
    end
  end

  assign sdo_pin_o = sdo_reg;
  assign sdo_pin_oe = sdo_oe_reg;
  // awake while converting or while the host holds select low
  assign awake = !cs_s || (state_reg == ST_CONV) || (state_reg == ST_POR);  // [RULE_01]

endmodule // adcsq_sequencer

// [adcsq_sequencer_sva.sv]
// port assertions for the serial readout sequencer
`timescale 1ns/1ns
module adcsq_sequencer_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // watched pins and status
  input wire logic cs_n_pin,
  input wire logic sck_pin_oe,
  input wire logic sck_pullup_en,
  input wire logic sdo_pin_o,
  input wire logic sdo_pin_oe,
  input wire logic conv_start,
  input wire logic conv_channel,
  input wire logic notch_50hz,
  input wire logic ext_osc_mode,
  input wire logic awake,
  input wire logic conv_busy
);
  logic [5:0] up_cnt_reg; // cycles since reset release, saturating
  logic up; // 63 cycles since reset release, past the bench's 20-cycle power-on hold
  ////////////////////////////////////////////////////////////////////////////
  // count cycles after reset so start-up pulses are not judged
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt_reg <= 6'h00;
    end else if (up_cnt_reg != 6'h3f) begin
      up_cnt_reg <= up_cnt_reg + 6'h01;
    end
  end
  assign up = (up_cnt_reg == 6'h3f);
  ////////////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // select held long enough to pass the synchronisers
  sequence s_cs_high; cs_n_pin [*6]; endsequence
  sequence s_cs_low; !cs_n_pin [*6]; endsequence
  sequence s_conv_shown; (conv_busy && sdo_pin_oe) [*2]; endsequence
  property p_sdo_off; s_cs_high |-> !sdo_pin_oe; endproperty
  property p_sdo_on; up ##0 s_cs_low |-> sdo_pin_oe; endproperty
  property p_awake; s_cs_low |-> awake; endproperty
  property p_sck_off; s_cs_high |-> !sck_pin_oe; endproperty
  property p_pullup; sck_pin_oe |-> sck_pullup_en; endproperty
  property p_start_busy; conv_start |-> ##[0:1] conv_busy; endproperty
  property p_busy_sdo; s_conv_shown |-> sdo_pin_o; endproperty
  property p_chan; up && conv_busy && $past(conv_busy) |-> $stable(conv_channel); endproperty
  property p_notch; notch_50hz |-> !ext_osc_mode; endproperty
  property p_sleep; (up && cs_n_pin && !conv_busy) [*8] |=> !conv_start; endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven while deselected");
  a_sdo_on: assert property (p_sdo_on) else $error("sdo not driven while selected");
  a_awake: assert property (p_awake) else $error("not awake while selected");
  a_sck_off: assert property (p_sck_off) else $error("sck driven while deselected");
  a_pullup: assert property (p_pullup) else $error("sck driven without pull-up");
  a_start_busy: assert property (p_start_busy) else $error("start without conversion");
  a_busy_sdo: assert property (p_busy_sdo) else $error("status low in conversion");
  a_chan: assert property (p_chan) else $error("channel moved mid conversion");
  a_notch: assert property (p_notch) else $error("notch and external clock both set");
  a_sleep: assert property (p_sleep) else $error("conversion left sleep unselected");
endmodule // adcsq_sequencer_sva

bind adcsq_sequencer adcsq_sequencer_sva u_sva (.mclk(mclk), .arst_n(arst_n),
  .cs_n_pin(cs_n_pin), .sck_pin_oe(sck_pin_oe), .sck_pullup_en(sck_pullup_en),
  .sdo_pin_o(sdo_pin_o), .sdo_pin_oe(sdo_pin_oe), .conv_start(conv_start),
  .conv_channel(conv_channel), .notch_50hz(notch_50hz), .ext_osc_mode(ext_osc_mode),
  .awake(awake), .conv_busy(conv_busy));

// [adcsq_host_model.sv]
// host reader that drives select and serial clock and samples data
`timescale 1ns/1ns
module adcsq_host_model (
  // clock
  input wire logic mclk,
  // serial link
  output logic cs_n,
  output logic sck_o,
  output logic sck_oe,
  input wire logic sdo_wire
);
  ////////////////////////////////////////////////////////////////////////////
  // idle: deselected, clock released to the pull-up
  initial begin
    cs_n = 1'b1;
    sck_o = 1'b0;
    sck_oe = 1'b0;
  end
  // wait n falling mclk edges
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // select; the clock level held around the select edge picks the mode
  task automatic select(input bit ext);
    sck_oe = 1'b1;
    sck_o = !ext;
    wt(4);
    cs_n = 1'b0;
    wt(6);
    sck_o = 1'b0;
    sck_oe = ext;
  endtask
  // drive n clocks, taking each bit just before the rising edge
  task automatic shift(input int n, output logic [31:0] w);
    w = '0;
    sck_oe = 1'b1;
    for (int i = 0; i < n; i++) begin
      wt(8);
      w = {w[30:0], sdo_wire};
      sck_o = 1'b1;
      wt(8);
      sck_o = 1'b0;
    end
  endtask
  // deselect, host clock drive left as it was
  task automatic release_cs();
    wt(2);
    cs_n = 1'b1;
  endtask
endmodule // adcsq_host_model

// [adcsq_sequencer_tb_top.sv]
// self-checking bench for the serial readout sequencer
`timescale 1ns/1ns
module adcsq_sequencer_tb_top;
  import adcsq_pkg::*;
  logic mclk, arst_n, frequency_select_pin, two_channel_variant, flt;
  logic result_valid, result_sign_flag, range_exceeded_flag;
  logic [RESULT_BITS-1:0] result_code;
  logic cs_n, host_sck, host_oe, sck_wire, sdo_wire;
  logic sck_pin_o, sck_pin_oe, sck_pullup_en, sdo_pin_o, sdo_pin_oe, conv_start, conv_channel;
  logic notch_50hz, ext_osc_mode, result_ready, awake, conv_busy, conv_clk_en;
  logic [23:0] exp_word; // word of the last finished conversion
  logic [21:0] res_q[$]; // results handed to the sequencer, in order
  int fails = 0, n_tests = 0, starts = 0;
  bit fe_on = 1'b1; // front end answers each conversion start
  bit exp_ch = 1'b0; // channel expected for the conversion under way
  ////////////////////////////////////////////////////////////////////////////
  // wires: released lines float with a changing pattern, the clock line reads high while its pull-up is on
  assign sck_wire = sck_pin_oe ? sck_pin_o : (host_oe ? host_sck : (sck_pullup_en ? 1'b1 : flt));
  assign sdo_wire = sdo_pin_oe ? sdo_pin_o : flt;
  adcsq_sequencer #(.POR_HOLD_CYCLES(20), .FO_IDLE_CYCLES(2000)) u_dut (.mclk(mclk),
    .arst_n(arst_n), .cs_n_pin(cs_n), .sck_pin_i(sck_wire), .sck_pin_o(sck_pin_o),
    .sck_pin_oe(sck_pin_oe), .sck_pullup_en(sck_pullup_en), .sdo_pin_o(sdo_pin_o),
    .sdo_pin_oe(sdo_pin_oe), .frequency_select_pin(frequency_select_pin),
    .two_channel_variant(two_channel_variant), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_clk_en(conv_clk_en), .null_tick(),
    .notch_50hz(notch_50hz),
    .ext_osc_mode(ext_osc_mode), .result_valid(result_valid), .result_ready(result_ready),
    .result_code(result_code), .result_sign_flag(result_sign_flag),
    .range_exceeded_flag(range_exceeded_flag), .awake(awake), .conv_busy(conv_busy));
  adcsq_host_model u_host (.mclk(mclk), .cs_n(cs_n), .sck_o(host_sck), .sck_oe(host_oe),
    .sdo_wire(sdo_wire));
  ////////////////////////////////////////////////////////////////////////////
  // clock, float pattern and start counter
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial flt = 1'b0;
  always @(posedge mclk) begin
    flt <= ~flt;
    if (conv_start === 1'b1) starts++;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #500_000;
    fails++;
    give_verdict();
  end
  // expected n bits: status, code, then ones past the word
  function automatic logic [31:0] want(input logic [23:0] e, input int n);
    logic [55:0] full;
    full = {e, 32'hffffffff};
    return 32'(full >> (56 - n));
  endfunction
  // hand one result to the sequencer
  task automatic push_result(input logic [21:0] d);
    @(negedge mclk);
    {result_sign_flag, range_exceeded_flag, result_code} = d;
    result_valid = 1'b1;
    @(posedge mclk);
    while (result_ready !== 1'b1) @(posedge mclk);
    res_q.push_back(d);
    @(negedge mclk);
    result_valid = 1'b0;
  endtask
  // front end: a result some time after each start
  initial forever begin
    @(posedge conv_start);
    if (fe_on) begin
      repeat (400) @(negedge mclk);
      push_result(22'($urandom));
    end
  end
  // expected word follows each finished conversion
  initial forever begin
    @(negedge conv_busy);
    if (res_q.size() > 0) begin
      exp_word = {1'b0, exp_ch, res_q.pop_front()};
      exp_ch = two_channel_variant && !exp_ch;
    end
  end
  // select in external mode, wait for end of conversion, read n bits
  task automatic read_word(input int n);
    int k, s0;
    logic [31:0] w;
    logic [23:0] e;
    s0 = starts;
    u_host.select(1'b1);
    check(32'(sck_pin_oe), 32'h0);
    k = 0;
    while (sdo_wire !== 1'b0 && k < 5000) begin
      u_host.wt(1);
      k++;
    end
    check(32'(k < 5000), 32'h1);
    e = exp_word;
    u_host.shift(n, w);
    u_host.release_cs();
    check(w, want(e, n));
    u_host.wt(10);
    check(32'(starts - s0), 32'h1);
    $display("test read of %0d bits done", n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int k, s0, n;
    logic [31:0] w;
    arst_n = 1'b0;
    frequency_select_pin = 1'b1;
    two_channel_variant = 1'b1;
    result_valid = 1'b0;
    {result_sign_flag, range_exceeded_flag, result_code} = 22'h000000;
    void'($urandom(98));
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    repeat (15) @(negedge mclk);
    check(32'(starts), 32'h0);
    // static levels count only after the idle window; one tick per divider period
    for (k = 0; k < 2; k++) begin
      frequency_select_pin = k[0];
      repeat (2100) @(negedge mclk);
      check(32'(notch_50hz), 32'(k));
      n = 0;
      repeat (int'(k[0] ? OSC_DIV_50 : OSC_DIV_60)) begin
        @(negedge mclk);
        n += int'(conv_clk_en);
      end
      check(32'(n), 32'h1);
    end
    check(32'(starts), 32'h1);
    repeat (60) begin
      repeat (10) @(negedge mclk);
      frequency_select_pin = ~frequency_select_pin;
    end
    check(32'(ext_osc_mode), 32'h1);
    repeat (2100) @(negedge mclk);
    check(32'(ext_osc_mode), 32'h0);
    $display("test frequency pin done");
    // internal clock mode: device drives the clock, then abort mid word
    s0 = starts;
    u_host.select(1'b0);
    check(32'(sck_pin_oe), 32'h1);
    check(32'(sck_pullup_en), 32'h1);
    k = 0;
    while (sck_wire !== 1'b1 && k < 8000) begin
      @(negedge mclk);
      k++;
    end
    check(32'(k < 8000), 32'h1);
    repeat (8) @(negedge mclk);
    u_host.release_cs();
    repeat (10) @(negedge mclk);
    check(32'(starts - s0), 32'h1);
    $display("test internal clock done");
    // external reads, clocks while deselected, aborts
    for (k = 0; k < 6; k++) begin
      s0 = starts;
      u_host.shift(6, w);
      check(32'(starts - s0), 32'h0);
      read_word((k == 3) ? 2 + int'($urandom % 20) : (k[0] ? 24 : 32));
    end
    // fill the buffer while asleep, then drain it by reading
    fe_on = 1'b0;
    two_channel_variant = 1'b0; // single-channel strap from the next conversion on
    repeat (500) @(negedge mclk);
    // code end points among the queued results
    for (k = 0; k < 4; k++) begin
      push_result((k == 0) ? 22'h000000 : ((k == 1) ? 22'h0fffff : 22'($urandom)));
    end
    check(32'(result_ready), 32'h0);
    repeat (4) read_word(24);
    check(32'(result_ready), 32'h1);
    $display("test buffer done");
    give_verdict();
  end
endmodule // adcsq_sequencer_tb_top
